// ==== common/hpoe_pkg.sv ====
package hpoe_pkg;

  // Clock and settle timing
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned SETTLE_US    = 20;
  // Least time: 20 us at 250 MHz is exactly 5000 cycles, rounding up is a no-op
  localparam int unsigned SETTLE_CYC   = (SETTLE_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned CNT_W        = 13;

  // Register indices; byte address is four times the index
  localparam logic [11:0] STAGE_IDX    = 12'h05A;
  localparam logic [11:0] STATUS_IDX   = 12'h05B;
  localparam logic [11:0] STAGE_ADDR   = {STAGE_IDX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR  = {STATUS_IDX[9:0], 2'b00};

  // Stage enable register layout
  localparam int unsigned LEFT_SHORT_BIT  = 7;
  localparam int unsigned LEFT_OUT_BIT    = 6;
  localparam int unsigned LEFT_MID_BIT    = 5;
  localparam int unsigned LEFT_IN_BIT     = 4;
  localparam int unsigned RIGHT_SHORT_BIT = 3;
  localparam int unsigned RIGHT_OUT_BIT   = 2;
  localparam int unsigned RIGHT_MID_BIT   = 1;
  localparam int unsigned RIGHT_IN_BIT    = 0;
  localparam logic [7:0]  STAGE_RESET     = 8'h00;

  // Field order inside one channel nibble
  localparam int unsigned NIB_IN    = 0;
  localparam int unsigned NIB_MID   = 1;
  localparam int unsigned NIB_OUT   = 2;
  localparam int unsigned NIB_SHORT = 3;
  localparam int unsigned NIB_W     = 4;

  // Status register layout, index 0 is right, 1 is left
  localparam int unsigned STAT_SETTLED_LSB = 0;
  localparam int unsigned STAT_FAULT_LSB   = 4;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {SEL_NONE, SEL_STAGE, SEL_STATUS} hpoe_sel_t;

endpackage

// ==== rtl/hpoe_chan.sv ====
`timescale 1ns/1ps
// Watches one channel's stage bits: input-stage settle timer and sticky order fault
module hpoe_chan
  import hpoe_pkg::*;
#(
  parameter logic [CNT_W-1:0] SETTLE = CNT_W'(SETTLE_CYC)
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Stage bits and fault clear of this channel
  input  wire logic [NIB_W-1:0] stage,
  input  wire logic             fault_clr,
  // State
  output logic                  settled,
  output logic                  fault
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [NIB_W-1:0] prev_r;
  logic             settled_r;
  logic             fault_r;
  logic             early;

  always_comb begin
    if (!stage[NIB_IN]) begin
      cnt_nxt = '0;
    end else if (cnt_r != SETTLE) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= '0;
      settled_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      settled_r <= (cnt_nxt == SETTLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= stage;
    end
  end

  // [R10] intermediate before settle
  // Intermediate on before the input stage settled, output on with intermediate off, or short removed with output off, is a fault;
  // the device still obeys the bit, software only sees the flag
  assign early = (stage[NIB_MID] & ~prev_r[NIB_MID] & ~settled_r)
               | (stage[NIB_OUT] & ~prev_r[NIB_OUT] & ~stage[NIB_MID])
               | (stage[NIB_SHORT] & ~prev_r[NIB_SHORT] & ~stage[NIB_OUT]);

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
    end else if (early) begin
      fault_r <= 1'b1;
    end else if (fault_clr) begin
      fault_r <= 1'b0;
    end
  end

  assign settled = settled_r;
  assign fault   = fault_r;

  fault_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    early |=> fault_r)
    else $error("order fault not flagged");

  settle_time_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    $rose(settled_r) |-> (cnt_r == SETTLE) && $past(stage[NIB_IN]))
    else $error("settled raised at wrong time");

endmodule

// ==== rtl/hpoe_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Bit 7 removes left output short
// [R2] Bit 3 removes right output short
// [R3] Bit 6 enables left output stage
// [R4] Bit 2 enables right output stage
// [R5] Bit 5 enables left intermediate stage
// [R6] Bit 1 enables right intermediate stage
// [R7] Bit 4 enables left input stage
// [R8] Bit 0 enables right input stage
// [R9] Software sets input stage first
// [R10] Intermediate stage at least 20us after input
// [R11] Intermediate after path set, before offset cancel
// [R12] Output stage after offset cancel scheduled
// [R13] Short removal is the last step
// [R14] Reset clears all eight bits
module hpoe_top
  import hpoe_pkg::*;
#(
  parameter logic [CNT_W-1:0] SETTLE = CNT_W'(SETTLE_CYC)
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Left headphone driver controls
  output logic             left_short_remove,
  output logic             left_output_stage_on,
  output logic             left_intermediate_stage_on,
  output logic             left_input_stage_on,
  // Right headphone driver controls
  output logic             right_short_remove,
  output logic             right_output_stage_on,
  output logic             right_intermediate_stage_on,
  output logic             right_input_stage_on
);

  function automatic hpoe_sel_t decode(input logic [11:0] a);
    if (a == STAGE_ADDR) begin
      return SEL_STAGE;
    end else if (a == STATUS_ADDR) begin
      return SEL_STATUS;
    end else begin
      return SEL_NONE;
    end
  endfunction

  logic [7:0]  stage_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [1:0]  settled;
  logic [1:0]  fault;
  logic [1:0]  fault_clr;
  logic [31:0] status;
  logic        setup;
  logic        done;
  logic        wr_stage;
  logic        wr_status;
  hpoe_sel_t   sel;

  assign sel       = decode(paddr);
  assign setup     = psel & ~penable;
  // A write lands only at the edge that completes the access phase
  assign done      = psel & penable & pready_r;
  assign wr_stage  = done & pwrite & pstrb[0] & (sel == SEL_STAGE);
  assign wr_status = done & pwrite & pstrb[0] & (sel == SEL_STATUS);
  assign fault_clr = wr_status ? pwdata[STAT_FAULT_LSB +: 2] : 2'b00;

  always_comb begin
    status = STATUS_RESET;
    status[STAT_SETTLED_LSB +: 2] = settled;
    status[STAT_FAULT_LSB +: 2]   = fault;
  end

  // No wait state; pready, prdata and pslverr all come straight from flops set in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup & (sel == SEL_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup & ~pwrite & (sel == SEL_STAGE)) begin
      prdata_r <= {24'h00_0000, stage_r};
    end else if (setup & ~pwrite & (sel == SEL_STATUS)) begin
      prdata_r <= status;
    end else if (setup) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // [R14] cleared on reset
  // Reset leaves every stage off and both shorts applied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= STAGE_RESET;
    end else if (wr_stage) begin
      stage_r <= pwdata[7:0];
    end
  end

  // [R9] sequence order watch
  // Right channel is nibble 0, left is nibble 1
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    hpoe_chan #(
      .SETTLE    (SETTLE)
    ) u_chan (
      .pclk      (pclk),
      .presetn   (presetn),
      .stage     (stage_r[ch*NIB_W +: NIB_W]),
      .fault_clr (fault_clr[ch]),
      .settled   (settled[ch]),
      .fault     (fault[ch])
    );
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // [R1] left short control
  assign left_short_remove           = stage_r[LEFT_SHORT_BIT];
  // [R3] left output stage
  assign left_output_stage_on        = stage_r[LEFT_OUT_BIT];
  // [R5] left intermediate stage
  assign left_intermediate_stage_on  = stage_r[LEFT_MID_BIT];
  // [R7] left input stage
  assign left_input_stage_on         = stage_r[LEFT_IN_BIT];
  // [R2] right short control
  assign right_short_remove          = stage_r[RIGHT_SHORT_BIT];
  // [R4] right output stage
  assign right_output_stage_on       = stage_r[RIGHT_OUT_BIT];
  // [R6] right intermediate stage
  assign right_intermediate_stage_on = stage_r[RIGHT_MID_BIT];
  // [R8] right input stage
  assign right_input_stage_on        = stage_r[RIGHT_IN_BIT];

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence stage_write_s;
    wr_stage;
  endsequence

  left_short_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    stage_write_s |=> left_short_remove == $past(pwdata[LEFT_SHORT_BIT]))
    else $error("left short bit not taken");

  right_short_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    stage_write_s |=> right_short_remove == $past(pwdata[RIGHT_SHORT_BIT]))
    else $error("right short bit not taken");

  left_output_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    stage_write_s ##1 !wr_stage |=> left_output_stage_on == $past(pwdata[LEFT_OUT_BIT], 2))
    else $error("left output stage not held");

  right_output_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    stage_write_s |=> right_output_stage_on == $past(pwdata[RIGHT_OUT_BIT]))
    else $error("right output stage not taken");

  left_mid_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    $rose(left_intermediate_stage_on) |-> $past(wr_stage) && $past(pwdata[LEFT_MID_BIT]))
    else $error("left intermediate rose without write");

  right_mid_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    $changed(right_intermediate_stage_on) |-> $past(wr_stage))
    else $error("right intermediate changed without write");

  left_input_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    stage_write_s |=> left_input_stage_on == $past(pwdata[LEFT_IN_BIT]))
    else $error("left input stage not taken");

  right_input_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    stage_write_s |=> right_input_stage_on == $past(pwdata[RIGHT_IN_BIT]))
    else $error("right input stage not taken");

  reset_clear_a: assert property (@(posedge pclk) // [R14]
    $rose(presetn) |-> (stage_r == STAGE_RESET) && !pready_r)
    else $error("stage bits not clear after reset");

  ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> pready_r ##1 !pready_r || setup)
    else $error("pready not one cycle after setup");

  readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s and (!pwrite && sel == SEL_STAGE) |=> prdata_r == {24'h00_0000, $past(stage_r)})
    else $error("stage readback wrong");

  status_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s and (!pwrite && sel == SEL_STATUS) |=> prdata_r == $past(status))
    else $error("status readback wrong");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s and (sel == SEL_NONE) |=> pslverr_r && pready_r && (prdata_r == 32'h0000_0000))
    else $error("unmapped access not refused");

  stage_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_stage |=> $stable(stage_r))
    else $error("stage bits changed without write");

endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import hpoe_pkg::*;
  localparam int SIM_SETTLE = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  pstrb;
  logic [7:0]  outs;
  logic        lsr, los, lis, lin, rsr, ros, ris, rin;
  int          num_errors = 0;
  int          checked = 0;

  assign outs = {lsr, los, lis, lin, rsr, ros, ris, rin};

  hpoe_top #(.SETTLE(CNT_W'(SIM_SETTLE))) u_hpoe_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .left_short_remove(lsr), .left_output_stage_on(los),
    .left_intermediate_stage_on(lis), .left_input_stage_on(lin), .right_short_remove(rsr),
    .right_output_stage_on(ros), .right_intermediate_stage_on(ris), .right_input_stage_on(rin)
  );

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready wait", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp, input string name);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk(name, exp, rd & mask);
  endtask

  initial begin
    #20000;
    num_errors++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("outputs after reset", 32'h0, {24'h0, outs});
    rdchk(STAGE_ADDR, 32'hFFFF_FFFF, 32'h0, "stage after reset");
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      wr(STAGE_ADDR, 32'h1 << i);
      #1 chk("single stage bit", 32'h1 << i, {24'h0, outs});
    end
    wr(STAGE_ADDR, 32'hFFFF_FF5A);
    rdchk(STAGE_ADDR, 32'hFFFF_FFFF, 32'h5A, "stage readback");
    apb(STAGE_ADDR, 1'b1, 32'hA5, 4'hE);
    #1 chk("low strobe off", 32'h5A, {24'h0, outs});
    wr(12'h000, 32'hFF);
    chk("unmapped write error", 32'h1, {31'h0, er});
    #1 chk("unmapped write ignored", 32'h5A, {24'h0, outs});
    $display("test register access done");

    // The single-bit writes above broke the order on purpose; clear their faults first
    wr(STAGE_ADDR, 32'h00);
    wr(STATUS_ADDR, 32'h30);
    rdchk(STATUS_ADDR, 32'hFFFF_FFFF, 32'h00, "faults cleared");
    // In-order enable of both channels raises no fault
    wr(STAGE_ADDR, 32'h11);
    repeat (SIM_SETTLE + 4) @(posedge pclk);
    rdchk(STATUS_ADDR, 32'hFFFF_FFFF, 32'h03, "settled status");
    wr(STAGE_ADDR, 32'h33);
    wr(STAGE_ADDR, 32'h77);
    wr(STAGE_ADDR, 32'hFF);
    rdchk(STATUS_ADDR, 32'hFFFF_FFFF, 32'h03, "in order status");
    // Early intermediate on right, early short removal on left
    wr(STAGE_ADDR, 32'h00);
    wr(STAGE_ADDR, 32'h01);
    wr(STAGE_ADDR, 32'h83);
    #1 chk("faulty bits obeyed", 32'h83, {24'h0, outs});
    rdchk(STATUS_ADDR, 32'h30, 32'h30, "order faults");
    wr(STATUS_ADDR, 32'h10);
    rdchk(STATUS_ADDR, 32'h30, 32'h20, "fault after clear");
    $display("test sequencing done");

    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("outputs after second reset", 32'h0, {24'h0, outs});
    rdchk(STAGE_ADDR, 32'hFFFF_FFFF, 32'h0, "stage after second reset");
    $display("test second reset done");
    conclude();
  end
endmodule
